// File: rtl/memory_attribution_checker.v
`include "mac_consts.vh"

// Functional notes
// - integrity regions check response checksums
// - no checksum fault without integrity
// - write responses never compare read data
// - grant and valid parity always checked
// - zero regions: main, plain, no integrity
// - unmatched address: I/O, plain, no integrity
// - every access checked, failures raise exception
// - checks cannot be switched off
// - match grain is 2^(exp+2) bytes
// - entries above count read zero
// - reset values from top parameters
// - standard protection with machine-mode extension
// - region match low <= addr < high
// - lowest index region wins overlap
// - fetch from I/O faults code 1
// - misaligned I/O load 5, store 7
module memory_attribution_checker #(
  parameter integer attr_region_count = 1,
  parameter [`MAC_PMA_W*`MAC_PMA_MAX-1:0] attr_cfg = {`MAC_PMA_W*`MAC_PMA_MAX{1'b0}},
  parameter integer prot_region_count = 16,
  parameter integer prot_grain_exponent = 0,
  parameter [8*`MAC_PROT_MAX-1:0] prot_entry_cfg_reset_vals = {8*`MAC_PROT_MAX{1'b0}},
  parameter [32*`MAC_PROT_MAX-1:0] prot_entry_addr_reset_vals = {32*`MAC_PROT_MAX{1'b0}},
  parameter [2:0] prot_security_cfg_reset_val = 3'h0
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire i_acc_valid,
  input wire [1:0] i_acc_kind,
  input wire [1:0] i_acc_size,
  input wire [31:0] i_acc_addr,
  input wire i_acc_machine,
  input wire i_acc_spec,
  output reg o_acc_done,
  output reg o_acc_fault,
  output reg [4:0] o_acc_cause,
  output reg o_acc_blocked,
  output reg o_instr_req,
  output reg o_data_req,
  output reg o_data_we,
  output reg [31:0] o_bus_addr,
  output reg [1:0] o_mem_type,
  output reg o_main,
  input wire i_instr_gnt,
  input wire i_instr_gntpar,
  input wire i_instr_rvalid,
  input wire i_instr_rvalidpar,
  input wire [31:0] i_instr_rdata,
  input wire i_instr_err,
  input wire [4:0] i_instr_rchk,
  input wire i_data_gnt,
  input wire i_data_gntpar,
  input wire i_data_rvalid,
  input wire i_data_rvalidpar,
  input wire [31:0] i_data_rdata,
  input wire i_data_err,
  input wire [4:0] i_data_rchk,
  output reg o_instr_chk_fault,
  output reg o_load_chk_nmi,
  output reg o_alert_major,
  output reg o_irq
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  localparam [31:0] grain_mask = ~((32'h1 << prot_grain_exponent) - 32'h1);

  function [3:0] rdata_chk;
    input [31:0] d;
    begin
      rdata_chk = {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
    end
  endfunction

  // care bits of a naturally aligned power-of-two range
  function [31:0] napot_care;
    input [31:0] a;
    begin
      napot_care = ~(a ^ (a + 32'h1)) & grain_mask;
    end
  endfunction

  function [4:0] kind_cause;
    input [1:0] k;
    begin
      case (k)
        `MAC_KIND_FETCH: kind_cause = `MAC_CAUSE_INSTR;
        `MAC_KIND_LOAD: kind_cause = `MAC_CAUSE_LOAD;
        default: kind_cause = `MAC_CAUSE_STORE;
      endcase
    end
  endfunction

  // ****************************************************************
  // protection state
  // ****************************************************************
  reg [7:0] cfg_q [0:`MAC_PROT_MAX-1];
  reg [31:0] addr_q [0:`MAC_PROT_MAX-1];
  reg [2:0] sec_q;
  reg [`MAC_EV_W-1:0] stat_q;
  reg [`MAC_EV_W-1:0] en_q;
  reg wr_pend_q;
  reg rd_pend_q;
  reg [5:0] idx_q;
  reg instr_integ_q;
  reg data_integ_q;
  reg data_we_q;
  integer i, lock_i, attr_i, prot_i;

  // ****************************************************************
  // bus slave address phase
  // ****************************************************************
  wire take = i_hsel & i_htrans[1] & i_hready & o_hreadyout;
  wire wr_now = wr_pend_q;
  wire [5:0] widx = idx_q;
  wire rlb = sec_q[`MAC_SEC_RLB];

  function entry_locked;
    input [7:0] c;
    input rl;
    begin
      entry_locked = c[`MAC_CFG_L] & ~rl;
    end
  endfunction

  reg any_locked;
  always @* begin
    any_locked = 1'b0;
    for (lock_i = 0; lock_i < `MAC_PROT_MAX; lock_i = lock_i + 1) begin
      any_locked = any_locked | cfg_q[lock_i][`MAC_CFG_L];
    end
  end

  // WARL legalisation of one configuration byte
  function [7:0] cfg_legal;
    input [7:0] v;
    input [7:0] old;
    input mml;
    reg [7:0] t;
    begin
      t = v & `MAC_CFG_WMASK;
      if ((prot_grain_exponent > 0) && (t[`MAC_CFG_A_HI:`MAC_CFG_A_LO] == `MAC_A_NA4)) begin
        t[`MAC_CFG_A_HI:`MAC_CFG_A_LO] = old[`MAC_CFG_A_HI:`MAC_CFG_A_LO];
      end
      if (!mml && !t[`MAC_CFG_R] && t[`MAC_CFG_W]) begin
        t[`MAC_CFG_W] = 1'b0;
      end
      cfg_legal = t;
    end
  endfunction

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (i = 0; i < `MAC_PROT_MAX; i = i + 1) begin
        cfg_q[i] <= (i < prot_region_count) ? prot_entry_cfg_reset_vals[8*i +: 8] : 8'h00;
        addr_q[i] <= (i < prot_region_count) ? prot_entry_addr_reset_vals[32*i +: 32] : 32'h0;
      end
      sec_q <= prot_security_cfg_reset_val;
    end else if (wr_now) begin
      for (i = 0; i < `MAC_PROT_MAX; i = i + 1) begin
        // entries at or above the count ignore writes, locked entries too
        if ((i < prot_region_count) && (widx == `MAC_IDX_CFG0 + i / 4) &&
            !entry_locked(cfg_q[i], rlb)) begin
          cfg_q[i] <= cfg_legal(i_hwdata[8*(i%4) +: 8], cfg_q[i], sec_q[`MAC_SEC_MML]);
        end
        if ((i < prot_region_count) && (widx == `MAC_IDX_ADDR0 + i) &&
            !entry_locked(cfg_q[i], rlb) &&
            !((i + 1 < prot_region_count) && entry_locked(cfg_q[(i + 1) % `MAC_PROT_MAX], rlb) &&
              (cfg_q[(i + 1) % `MAC_PROT_MAX][`MAC_CFG_A_HI:`MAC_CFG_A_LO] == `MAC_A_TOR))) begin
          addr_q[i] <= i_hwdata;
        end
      end
      if (widx == `MAC_IDX_SEC) begin
        // machine-mode lock bits are sticky; rule-lock bypass writable only while it is set or nothing is locked
        sec_q[`MAC_SEC_MML] <= sec_q[`MAC_SEC_MML] | i_hwdata[`MAC_SEC_MML];
        sec_q[`MAC_SEC_MMWP] <= sec_q[`MAC_SEC_MMWP] | i_hwdata[`MAC_SEC_MMWP];
        if (rlb || !any_locked) begin
          sec_q[`MAC_SEC_RLB] <= i_hwdata[`MAC_SEC_RLB];
        end
      end
    end
  end

  // ****************************************************************
  // bus slave control and read data
  // ****************************************************************
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    if (idx_q <= `MAC_IDX_CFG3) begin
      rd_d = {cfg_q[4*idx_q[1:0]+3], cfg_q[4*idx_q[1:0]+2], cfg_q[4*idx_q[1:0]+1],
              cfg_q[4*idx_q[1:0]]};
    end else if ((idx_q >= `MAC_IDX_ADDR0) && (idx_q <= `MAC_IDX_ADDR15)) begin
      rd_d = addr_q[idx_q[3:0]];
    end else if (idx_q == `MAC_IDX_SEC) begin
      rd_d = {29'h0, sec_q};
    end else if (idx_q == `MAC_IDX_ISTAT) begin
      rd_d = {{(32-`MAC_EV_W){1'b0}}, stat_q};
    end else if (idx_q == `MAC_IDX_IEN) begin
      rd_d = {{(32-`MAC_EV_W){1'b0}}, en_q};
    end
  end

  // reads take one wait state so a write just before them is already stored
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 6'h00;
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_pend_q <= take & i_hwrite;
      rd_pend_q <= take & ~i_hwrite;
      if (take) begin
        idx_q <= i_haddr[7:2];
      end
      if (take & ~i_hwrite) begin
        o_hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        o_hrdata <= rd_d;
        o_hreadyout <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // attribution lookup
  // ****************************************************************
  wire [33:0] acc_addr34 = {2'b00, i_acc_addr};
  reg pma_main;
  reg pma_buf;
  reg pma_cache;
  reg pma_integ;
  always @* begin
    pma_main = (attr_region_count == 0);
    pma_buf = 1'b0;
    pma_cache = 1'b0;
    pma_integ = 1'b0;
    // walk from the top so the lowest matching index is applied last
    for (attr_i = `MAC_PMA_MAX - 1; attr_i >= 0; attr_i = attr_i - 1) begin
      if ((attr_i < attr_region_count) &&
          (acc_addr34 >= {attr_cfg[`MAC_PMA_W*attr_i+`MAC_PMA_LO_LO +: 32], 2'b00}) &&
          (acc_addr34 < {attr_cfg[`MAC_PMA_W*attr_i+`MAC_PMA_HI_LO +: 32], 2'b00})) begin
        pma_main = attr_cfg[`MAC_PMA_W*attr_i+`MAC_PMA_MAIN];
        pma_buf = attr_cfg[`MAC_PMA_W*attr_i+`MAC_PMA_BUF];
        pma_cache = attr_cfg[`MAC_PMA_W*attr_i+`MAC_PMA_CACHE];
        pma_integ = attr_cfg[`MAC_PMA_W*attr_i+`MAC_PMA_INTEG];
      end
    end
  end

  wire misalign = ((i_acc_size == `MAC_SIZE_HALF) && i_acc_addr[0]) ||
                  ((i_acc_size == `MAC_SIZE_WORD) && (i_acc_addr[1:0] != 2'b00));
  wire is_fetch = (i_acc_kind == `MAC_KIND_FETCH);
  wire is_store = (i_acc_kind == `MAC_KIND_STORE);
  wire attr_fail = !pma_main && (is_fetch || misalign);

  // ****************************************************************
  // protection lookup
  // ****************************************************************
  wire [31:0] acc_word = acc_addr34[33:2];
  reg prot_hit;
  reg [7:0] prot_cfg;
  reg [31:0] prev_w;
  reg match;
  always @* begin
    prot_hit = 1'b0;
    prot_cfg = 8'h00;
    prev_w = 32'h0;
    match = 1'b0;
    for (prot_i = 0; prot_i < `MAC_PROT_MAX; prot_i = prot_i + 1) begin
      case (cfg_q[prot_i][`MAC_CFG_A_HI:`MAC_CFG_A_LO])
        `MAC_A_TOR: match = ((acc_word & grain_mask) >= (prev_w & grain_mask)) &&
                            ((acc_word & grain_mask) < (addr_q[prot_i] & grain_mask));
        `MAC_A_NA4: match = (acc_word == addr_q[prot_i]);
        `MAC_A_NAPOT: match = (((acc_word ^ addr_q[prot_i]) & napot_care(addr_q[prot_i])) == 32'h0);
        default: match = 1'b0;
      endcase
      if (match && !prot_hit && (prot_i < prot_region_count)) begin
        prot_hit = 1'b1;
        prot_cfg = cfg_q[prot_i];
      end
      prev_w = addr_q[prot_i];
    end
  end

  reg perm;
  reg applies;
  reg prot_fail;
  always @* begin
    case (i_acc_kind)
      `MAC_KIND_FETCH: perm = prot_cfg[`MAC_CFG_X];
      `MAC_KIND_LOAD: perm = prot_cfg[`MAC_CFG_R];
      default: perm = prot_cfg[`MAC_CFG_W];
    endcase
    // with machine-mode lockdown, locked entries belong to machine mode only
    if (sec_q[`MAC_SEC_MML]) begin
      applies = (prot_cfg[`MAC_CFG_L] == i_acc_machine);
    end else begin
      applies = !i_acc_machine || prot_cfg[`MAC_CFG_L];
    end
    if (prot_hit) begin
      prot_fail = (applies && !perm) || (!applies && sec_q[`MAC_SEC_MML]);
    end else begin
      prot_fail = !i_acc_machine || sec_q[`MAC_SEC_MMWP];
    end
  end

  // ****************************************************************
  // access decision, every access goes through, no bypass exists
  // ****************************************************************
  wire acc_fail = attr_fail | prot_fail;
  wire spec_io = i_acc_spec & ~pma_main & ~acc_fail;
  wire issue = i_acc_valid & ~acc_fail & ~spec_io;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_acc_done <= 1'b0;
      o_acc_fault <= 1'b0;
      o_acc_cause <= 5'h00;
      o_acc_blocked <= 1'b0;
      o_instr_req <= 1'b0;
      o_data_req <= 1'b0;
      o_data_we <= 1'b0;
      o_bus_addr <= 32'h0;
      o_mem_type <= 2'b00;
      o_main <= 1'b0;
      instr_integ_q <= 1'b0;
      data_integ_q <= 1'b0;
      data_we_q <= 1'b0;
    end else begin
      o_acc_done <= i_acc_valid;
      o_acc_fault <= i_acc_valid & acc_fail;
      o_acc_cause <= (i_acc_valid & acc_fail) ? kind_cause(i_acc_kind) : 5'h00;
      o_acc_blocked <= i_acc_valid & spec_io;
      o_instr_req <= issue & is_fetch;
      o_data_req <= issue & ~is_fetch;
      if (issue) begin
        o_data_we <= is_store;
        o_bus_addr <= i_acc_addr;
        o_mem_type <= {pma_cache, pma_buf & is_store};
        o_main <= pma_main;
      end
      if (issue & is_fetch) begin
        instr_integ_q <= pma_integ;
      end
      if (issue & ~is_fetch) begin
        data_integ_q <= pma_integ;
        data_we_q <= is_store;
      end
    end
  end

  // ****************************************************************
  // response checking
  // ****************************************************************
  wire par_err = (i_instr_gntpar == i_instr_gnt) || (i_instr_rvalidpar == i_instr_rvalid) ||
                 (i_data_gntpar == i_data_gnt) || (i_data_rvalidpar == i_data_rvalid);
  wire instr_chk_err = i_instr_rvalid & instr_integ_q &
                       (i_instr_rchk != {~i_instr_err, rdata_chk(i_instr_rdata)});
  wire data_chk_err = i_data_rvalid & data_integ_q &
                      ((i_data_rchk[4] != ~i_data_err) ||
                       (!data_we_q && (i_data_rchk[3:0] != rdata_chk(i_data_rdata))));

  wire [`MAC_EV_W-1:0] ev;
  assign ev[`MAC_EV_ATTR] = i_acc_valid & attr_fail;
  assign ev[`MAC_EV_PROT] = i_acc_valid & prot_fail;
  assign ev[`MAC_EV_PAR] = par_err;
  assign ev[`MAC_EV_CHK] = instr_chk_err | data_chk_err;

  wire [`MAC_EV_W-1:0] clr = (wr_now && (widx == `MAC_IDX_ICLR)) ?
                             i_hwdata[`MAC_EV_W-1:0] : {`MAC_EV_W{1'b0}};
  wire [`MAC_EV_W-1:0] stat_d = (stat_q & ~clr) | ev;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_instr_chk_fault <= 1'b0;
      o_load_chk_nmi <= 1'b0;
      o_alert_major <= 1'b0;
      stat_q <= {`MAC_EV_W{1'b0}};
      en_q <= {`MAC_EV_W{1'b0}};
      o_irq <= 1'b0;
    end else begin
      o_instr_chk_fault <= instr_chk_err;
      o_load_chk_nmi <= data_chk_err & ~data_we_q;
      o_alert_major <= par_err | instr_chk_err | data_chk_err;
      stat_q <= stat_d;
      if (wr_now && (widx == `MAC_IDX_IEN)) begin
        en_q <= i_hwdata[`MAC_EV_W-1:0];
      end
      o_irq <= |(stat_d & ((wr_now && (widx == `MAC_IDX_IEN)) ?
                           i_hwdata[`MAC_EV_W-1:0] : en_q));
    end
  end
endmodule // memory_attribution_checker

// File: include/mac_consts.vh
`ifndef MAC_CONSTS_VH
`define MAC_CONSTS_VH
// ****************************************************************
// register map, word index on the slave port (byte address bits 7:2)
// ****************************************************************
`define MAC_IDX_CFG0 6'h00
`define MAC_IDX_CFG3 6'h03
`define MAC_IDX_ADDR0 6'h10
`define MAC_IDX_ADDR15 6'h1f
`define MAC_IDX_SEC 6'h20
`define MAC_IDX_ISTAT 6'h24
`define MAC_IDX_IEN 6'h25
`define MAC_IDX_ICLR 6'h26
// ****************************************************************
// protection entry configuration byte
// ****************************************************************
`define MAC_CFG_R 0
`define MAC_CFG_W 1
`define MAC_CFG_X 2
`define MAC_CFG_A_LO 3
`define MAC_CFG_A_HI 4
`define MAC_CFG_L 7
`define MAC_CFG_WMASK 8'h9f
`define MAC_A_OFF 2'h0
`define MAC_A_TOR 2'h1
`define MAC_A_NA4 2'h2
`define MAC_A_NAPOT 2'h3
`define MAC_SEC_MML 0
`define MAC_SEC_MMWP 1
`define MAC_SEC_RLB 2
`define MAC_PROT_MAX 16
// ****************************************************************
// attribution region layout: low word, high word, main, buf, cache, integ
// ****************************************************************
`define MAC_PMA_W 68
`define MAC_PMA_LO_HI 67
`define MAC_PMA_LO_LO 36
`define MAC_PMA_HI_HI 35
`define MAC_PMA_HI_LO 4
`define MAC_PMA_MAIN 3
`define MAC_PMA_BUF 2
`define MAC_PMA_CACHE 1
`define MAC_PMA_INTEG 0
`define MAC_PMA_MAX 16
// ****************************************************************
// access kinds, sizes, exception codes, events
// ****************************************************************
`define MAC_KIND_FETCH 2'h0
`define MAC_KIND_LOAD 2'h1
`define MAC_KIND_STORE 2'h2
`define MAC_SIZE_HALF 2'h1
`define MAC_SIZE_WORD 2'h2
`define MAC_CAUSE_INSTR 5'h01
`define MAC_CAUSE_LOAD 5'h05
`define MAC_CAUSE_STORE 5'h07
`define MAC_EV_W 4
`define MAC_EV_ATTR 0
`define MAC_EV_PROT 1
`define MAC_EV_PAR 2
`define MAC_EV_CHK 3
`endif

// File: testbench/bus_responder.sv
module bus_responder (
  input logic i_clk,
  input logic i_req,
  input logic i_bad_chk,
  input logic i_bad_par,
  output logic o_gnt,
  output logic o_gntpar,
  output logic o_rvalid,
  output logic o_rvalidpar,
  output logic o_err,
  output logic [31:0] o_rdata,
  output logic [4:0] o_rchk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] d;
  initial {o_gnt, o_gntpar, o_rvalid, o_rvalidpar, o_err, o_rdata, o_rchk} = {5'h0a, 32'h0, 5'h1f};
  // grant one cycle after request, response the cycle after; data churns when idle
  always @(posedge i_clk) begin
    d = $urandom;
    o_gnt <= i_req;
    o_gntpar <= ~i_req ^ (i_req & i_bad_par);
    o_rvalid <= o_gnt;
    o_rvalidpar <= ~o_gnt;
    o_rdata <= d;
    o_rchk <= {1'b1, ~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0] ^ (i_bad_chk & o_gnt)};
  end
endmodule // bus_responder

// File: testbench/memory_attribution_checker_chk.sv
`include "mac_consts.vh"

module mac_chk (
  input logic i_clk,
  input logic i_resetn,
  input logic i_acc_valid,
  input logic [1:0] i_acc_kind,
  input logic [1:0] i_acc_size,
  input logic [31:0] i_acc_addr,
  input logic i_acc_spec,
  input logic o_acc_done,
  input logic o_acc_fault,
  input logic [4:0] o_acc_cause,
  input logic o_instr_req,
  input logic o_data_req,
  input logic o_data_we,
  input logic [31:0] o_bus_addr,
  input logic [1:0] o_mem_type,
  input logic o_main,
  input logic i_data_gnt,
  input logic i_data_gntpar,
  input logic o_alert_major,
  input logic o_load_chk_nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_acc_answered: assert property (i_acc_valid |=> o_acc_done)
    else $error("access not answered");
  a_fault_noreq: assert property (o_acc_fault |-> !o_instr_req && !o_data_req)
    else $error("request issued for faulting access");
  a_fetch_main: assert property (o_instr_req |-> o_main && !o_mem_type[0])
    else $error("fetch issued outside main memory");
  a_cause_kind: assert property (o_acc_fault |-> o_acc_cause ==
    ($past(i_acc_kind) == `MAC_KIND_FETCH ? `MAC_CAUSE_INSTR :
    $past(i_acc_kind) == `MAC_KIND_LOAD ? `MAC_CAUSE_LOAD : `MAC_CAUSE_STORE))
    else $error("wrong fault cause");
  a_spec_main: assert property (o_data_req && $past(i_acc_spec) |-> o_main)
    else $error("speculative access issued to io");
  a_misalign_main: assert property (o_data_req && $past(i_acc_addr[0]) &&
    $past(i_acc_size) == `MAC_SIZE_HALF |-> o_main)
    else $error("misaligned access issued to io");
  a_req_addr: assert property (o_data_req |-> o_bus_addr == $past(i_acc_addr) &&
    o_data_we == ($past(i_acc_kind) == `MAC_KIND_STORE))
    else $error("issued address or direction wrong");
  a_par_alert: assert property (i_data_gntpar == i_data_gnt |=> o_alert_major)
    else $error("grant parity error not flagged");
  a_nmi_alert: assert property (o_load_chk_nmi |-> o_alert_major)
    else $error("checksum nmi without alert");
endmodule // mac_chk

bind memory_attribution_checker mac_chk u_mac_chk (.i_clk, .i_resetn, .i_acc_valid,
  .i_acc_kind, .i_acc_size, .i_acc_addr, .i_acc_spec, .o_acc_done, .o_acc_fault, .o_acc_cause,
  .o_instr_req, .o_data_req, .o_data_we, .o_bus_addr, .o_mem_type, .o_main, .i_data_gnt,
  .i_data_gntpar, .o_alert_major, .o_load_chk_nmi);

// File: testbench/tb_memory_attribution_checker.sv
module tb_memory_attribution_checker;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [67:0] reg0 = {32'h100, 32'h200, 4'hf};
  localparam [67:0] reg1 = {32'h100, 32'h400, 4'h2};
  logic i_clk = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, i_acc_valid = 1'b0;
  logic i_acc_machine = 1'b0, i_acc_spec = 1'b0, ibad = 1'b0, dbad = 1'b0, dpar = 1'b0;
  logic [1:0] i_htrans = 2'h0, i_acc_kind = 2'h0, i_acc_size = 2'h0, o_mem_type;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, i_acc_addr = 32'h0, o_hrdata, o_bus_addr, rd;
  logic [31:0] i_instr_rdata, i_data_rdata;
  logic [4:0] o_acc_cause, i_instr_rchk, i_data_rchk;
  logic o_hreadyout, o_hresp, o_acc_done, o_acc_fault, o_acc_blocked, o_instr_req, o_data_req;
  logic o_data_we, o_main, i_instr_gnt, i_instr_gntpar, i_instr_rvalid, i_instr_rvalidpar;
  logic i_instr_err, i_data_gnt, i_data_gntpar, i_data_rvalid, i_data_rvalidpar, i_data_err;
  logic o_instr_chk_fault, o_load_chk_nmi, o_alert_major, o_irq, flat_fault, flat_main;
  logic [1:0] flat_mtype;
  integer mismatches = 0, compares = 0, nmi_n = 0, ichk_n = 0, alert_n = 0, k;

  memory_attribution_checker #(
    .attr_region_count(2),
    .attr_cfg({{14{68'h0}}, reg1, reg0}),
    .prot_region_count(4),
    .prot_entry_cfg_reset_vals({{11{8'h00}}, 8'h1f, {4{8'h00}}}),
    .prot_entry_addr_reset_vals({{10{32'h0}}, 32'hdead0001, 64'h0, 32'habc, 32'h0, 32'h12345678}),
    .prot_security_cfg_reset_val(3'h4)
  ) u_memory_attribution_checker (.*, .i_hready(o_hreadyout), .i_hsize(3'h2));

  // no attribution regions: everything is plain main memory
  memory_attribution_checker #(
    .attr_region_count(0)
  ) u_memory_attribution_checker_flat (.*, .i_hready(o_hreadyout), .i_hsize(3'h2), .o_hrdata(),
    .o_hreadyout(), .o_hresp(), .o_acc_done(), .o_acc_fault(flat_fault), .o_acc_cause(),
    .o_acc_blocked(), .o_instr_req(), .o_data_req(), .o_data_we(), .o_bus_addr(),
    .o_mem_type(flat_mtype), .o_main(flat_main), .o_instr_chk_fault(), .o_load_chk_nmi(),
    .o_alert_major(), .o_irq());

  bus_responder u_instr_bus (.i_clk, .i_req(o_instr_req), .i_bad_chk(ibad), .i_bad_par(1'b0),
    .o_gnt(i_instr_gnt), .o_gntpar(i_instr_gntpar), .o_rvalid(i_instr_rvalid),
    .o_rvalidpar(i_instr_rvalidpar), .o_err(i_instr_err), .o_rdata(i_instr_rdata),
    .o_rchk(i_instr_rchk));
  bus_responder u_data_bus (.i_clk, .i_req(o_data_req), .i_bad_chk(dbad), .i_bad_par(dpar),
    .o_gnt(i_data_gnt), .o_gntpar(i_data_gntpar), .o_rvalid(i_data_rvalid),
    .o_rvalidpar(i_data_rvalidpar), .o_err(i_data_err), .o_rdata(i_data_rdata),
    .o_rchk(i_data_rchk));

  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    nmi_n += (o_load_chk_nmi === 1'b1);
    ichk_n += (o_instr_chk_fault === 1'b1);
    alert_n += (o_alert_major === 1'b1);
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask

  task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(nm, rd, e);
    chk("hresp", o_hresp, 0);
  endtask

  // reference model of one access: attributes, faults and issue
  task acc(input integer kd, input integer sz, input logic [31:0] a, input integer mc,
           input integer sp);
    integer m, c, f, bl, mis;
    i_acc_valid <= 1'b1;
    i_acc_kind <= kd[1:0];
    i_acc_size <= sz[1:0];
    i_acc_addr <= a;
    i_acc_machine <= mc[0];
    i_acc_spec <= sp[0];
    @(posedge i_clk);
    i_acc_valid <= 1'b0;
    @(negedge i_clk);
    m = (a >= 32'h400 && a < 32'h800);
    c = (a >= 32'h400 && a < 32'h1000);
    mis = (sz == 1 && a[0]) || (sz == 2 && a[1:0] != 2'h0);
    f = !mc || (!m && (kd == 0 || mis));
    bl = !f && !m && sp;
    chk("done", o_acc_done, 1);
    chk("fault", o_acc_fault, f);
    chk("cause", o_acc_cause, !f ? 0 : kd == 0 ? 1 : kd == 1 ? 5 : 7);
    chk("blocked", o_acc_blocked, bl);
    chk("ireq", o_instr_req, !f && !bl && kd == 0);
    chk("dreq", o_data_req, !f && !bl && kd != 0);
    if (!f && !bl) begin
      chk("addr", o_bus_addr, a);
      chk("main", o_main, m);
      chk("mtype", o_mem_type, {c[0], m[0] && kd == 2});
    end
    chk("flat fault", flat_fault, !mc);
    if (mc) begin
      chk("flat main", {flat_main, flat_mtype}, 3'h4);
    end
    @(posedge i_clk);
  endtask

  task close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    close_out;
  end

  initial begin
    void'($urandom(32'h6c25));
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rdc("addr0", 32'h40, 32'h12345678);
    rdc("addr2", 32'h48, 32'habc);
    rdc("addr5", 32'h54, 32'h0);
    rdc("cfg1", 32'h04, 32'h0);
    rdc("sec", 32'h80, 32'h4);
    rdc("unmapped", 32'hfc, 32'h0);
    k = $urandom;
    ahb(1'b1, 32'h44, k, rd);
    rdc("addr1", 32'h44, k);
    ahb(1'b1, 32'h54, k, rd);
    rdc("addr5w", 32'h54, 32'h0);
    $display("test registers done");
    acc(0, 2, 32'h400, 1, 0);
    acc(0, 2, 32'h800, 1, 0);
    acc(0, 2, 32'h2000, 1, 0);
    acc(1, 1, 32'h801, 1, 0);
    acc(2, 2, 32'h802, 1, 0);
    acc(2, 2, 32'h404, 1, 0);
    acc(2, 1, 32'h7ff, 1, 0);
    acc(1, 0, 32'h801, 1, 0);
    acc(1, 2, 32'h900, 1, 1);
    acc(1, 2, 32'h400, 1, 1);
    acc(1, 2, 32'h400, 0, 0);
    repeat (40) begin
      k = $urandom % 3;
      acc(k, $urandom % 3, $urandom & 32'h1fff, ($urandom % 8) != 0, k != 0 && $urandom % 2);
    end
    $display("test attribution done");
    k = alert_n;
    dbad <= 1'b1;
    acc(1, 2, 32'h400, 1, 0);
    repeat (5) @(posedge i_clk);
    chk("nmi integ", nmi_n, 1);
    acc(1, 2, 32'h900, 1, 0);
    repeat (5) @(posedge i_clk);
    chk("nmi io", nmi_n, 1);
    acc(2, 2, 32'h404, 1, 0);
    repeat (5) @(posedge i_clk);
    chk("alert", alert_n - k, 1);
    dbad <= 1'b0;
    ibad <= 1'b1;
    acc(0, 2, 32'h400, 1, 0);
    repeat (5) @(posedge i_clk);
    chk("ichk", ichk_n, 1);
    ibad <= 1'b0;
    dpar <= 1'b1;
    acc(1, 2, 32'h900, 1, 0);
    dpar <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk("alert par", alert_n - k, 3);
    $display("test integrity done");
    ahb(1'b1, 32'h98, 32'hf, rd);
    ahb(1'b1, 32'h94, 32'h1, rd);
    acc(0, 2, 32'h800, 1, 0);
    repeat (2) @(posedge i_clk);
    chk("irq", o_irq, 1);
    rdc("status", 32'h90, 32'h1);
    ahb(1'b1, 32'h98, 32'h1, rd);
    repeat (2) @(posedge i_clk);
    chk("irq clr", o_irq, 0);
    ahb(1'b1, 32'h94, 32'h0, rd);
    acc(0, 2, 32'h800, 1, 0);
    repeat (2) @(posedge i_clk);
    chk("irq mask", o_irq, 0);
    rdc("status m", 32'h90, 32'h1);
    rdc("enable", 32'h94, 32'h0);
    $display("test interrupt done");
    close_out;
  end
endmodule // tb_memory_attribution_checker
